// ==== hw/wss_pkg.sv ====
// constants, types and state layout of the waveform sequence slots block
// Overview of operation
// - delay flag makes slot an idle period
// - idle lasts ten milliseconds times slot value
// - clear flag means low bits are effect
// - effect index selects library waveform position
// - trigger starts sequence at first slot
// - finished waveform advances to next slot
// - zero effect index stops without playing
// - sequence ends after the second slot, as slots three to eight read as a zero index
// - trigger stays high until sequence finishes
// - host clearing trigger aborts sequence immediately
package wss_pkg;
  // clock and delay timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DELAY_STEP_MS = 10;
  localparam int DELAY_STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam int UNIT_W = 17;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h0C;
  localparam logic [7:0] IDX_SLOT_ONE = 8'h0F;
  localparam logic [7:0] IDX_SLOT_TWO = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h30;
  localparam logic [7:0] ADDR_SLOT_ONE = 8'h3C;
  localparam logic [7:0] ADDR_SLOT_TWO = 8'h40;
  // reset values
  localparam logic [7:0] SLOT_ONE_RST = 8'h01;
  localparam logic [7:0] SLOT_TWO_RST = 8'h00;
  // field positions
  localparam int DELAY_FLAG_BIT = 7;
  localparam int TRIG_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int IDX_LSB = 2;
  // sequence length
  localparam logic [2:0] FIRST_SLOT = 3'h0;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [2:0] HELD_SLOTS = 3'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_ONE = 2'h2;
  localparam logic [1:0] SEL_TWO = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_PLAY = 4'h4,
    ST_WAIT = 4'h8
  } wss_state_t;

  // whole state of the top module
  typedef struct packed {
    wss_state_t st;
    logic trig;
    logic [2:0] idx;
    logic [1:0][7:0] slot;
    logic [UNIT_W-1:0] unit;
    logic [6:0] ticks;
    logic [6:0] eff_idx;
    logic eff_start;
    logic abort;
    logic idle;
    logic busy;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } wss_regs_t;
endpackage

// ==== hw/wss_top.sv ====
// waveform sequence slots: register file, sequencer and axi4-lite slave
`timescale 1ns/1ps
module wss_top #(
  parameter int DELAY_CYCLES = wss_pkg::DELAY_STEP_CYCLES
)
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // axi4-lite write channels
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  // axi4-lite read channels
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  // external trigger pin
  input wire logic EXT_TRIG_IN,
  // playback engine side
  output logic [6:0] EFFECT_INDEX_OUT,
  output logic EFFECT_START_OUT,
  output logic PLAY_ABORT_OUT,
  input wire logic EFFECT_DONE_IN,
  output logic IDLE_OUT,
  output logic BUSY_OUT
);
  wss_pkg::wss_regs_t s_q; // registered state
  wss_pkg::wss_regs_t s_d; // next state
  logic [7:0] cur_slot; // slot under the sequencer pointer
  logic host_clr; // host write that clears the trigger
  logic trig_set; // host or pin request to start

  // delay unit counter limits; DELAY_CYCLES must fit the unit counter or the step is cut short
  localparam int UNIT_LAST_I = DELAY_CYCLES - 1;
  localparam logic [wss_pkg::UNIT_W-1:0] UNIT_LAST = UNIT_LAST_I[wss_pkg::UNIT_W-1:0];
  localparam logic [wss_pkg::UNIT_W-1:0] UNIT_ONE = {{(wss_pkg::UNIT_W-1){1'b0}}, 1'b1};

  // address decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    case (addr)
      wss_pkg::ADDR_CTRL: reg_sel = wss_pkg::SEL_CTRL;
      wss_pkg::ADDR_SLOT_ONE: reg_sel = wss_pkg::SEL_ONE;
      wss_pkg::ADDR_SLOT_TWO: reg_sel = wss_pkg::SEL_TWO;
      default: reg_sel = wss_pkg::SEL_NONE;
    endcase
  endfunction

  // slots three to eight are not held here and read as a zero index
  assign cur_slot = (s_q.idx < wss_pkg::HELD_SLOTS) ? s_q.slot[s_q.idx[0]] : 8'h00;

  // next-state logic for bus, registers and sequencer
  always_comb
  begin
    logic wr_fire;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic advance;
    logic finish;
    wr_fire = 1'b0;
    wsel = wss_pkg::SEL_NONE;
    rsel = wss_pkg::SEL_NONE;
    advance = 1'b0;
    finish = 1'b0;
    host_clr = 1'b0;
    trig_set = 1'b0;
    s_d = s_q;
    s_d.eff_start = 1'b0;
    s_d.abort = 1'b0;
    // pin synchroniser and edge history
    s_d.ext_s1 = EXT_TRIG_IN;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    // capture address and data independently, in either order
    if (AWVALID_IN && s_q.awrdy)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && s_q.wrdy)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = WDATA_IN[7:0];
      s_d.w_strb0 = WSTRB_IN[0];
    end
    // write acts once both halves are held and the response slot is free
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid)
    begin
      wr_fire = 1'b1;
      wsel = reg_sel(s_q.aw_addr);
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wsel == wss_pkg::SEL_NONE) ? wss_pkg::RESP_SLVERR : wss_pkg::RESP_OKAY;
    end
    else if (s_q.bvalid && BREADY_IN)
    begin
      s_d.bvalid = 1'b0;
    end
    s_d.awrdy = !s_d.aw_held && !s_d.bvalid;
    s_d.wrdy = !s_d.w_held && !s_d.bvalid;
    // slot stores take the low byte lane only
    if (wr_fire && s_q.w_strb0)
    begin
      if (wsel == wss_pkg::SEL_ONE)
      begin
        s_d.slot[0] = s_q.w_data;
      end
      if (wsel == wss_pkg::SEL_TWO)
      begin
        s_d.slot[1] = s_q.w_data;
      end
      if (wsel == wss_pkg::SEL_CTRL)
      begin
        trig_set = s_q.w_data[wss_pkg::TRIG_BIT];
        host_clr = !s_q.w_data[wss_pkg::TRIG_BIT];
      end
    end
    // pin rising edge acts like a host write of one
    if (s_q.ext_s2 && !s_q.ext_s3)
    begin
      trig_set = 1'b1;
    end
    // read path: one read in flight, answered the cycle after address
    if (ARVALID_IN && s_q.arrdy)
    begin
      rsel = reg_sel(ARADDR_IN);
      s_d.rvalid = 1'b1;
      s_d.rresp = wss_pkg::RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      case (rsel)
        wss_pkg::SEL_CTRL:
        begin
          s_d.rdata[wss_pkg::TRIG_BIT] = s_q.trig;
          s_d.rdata[wss_pkg::BUSY_BIT] = s_q.busy;
          s_d.rdata[wss_pkg::IDX_LSB +: 3] = s_q.idx;
        end
        wss_pkg::SEL_ONE: s_d.rdata[7:0] = s_q.slot[0];
        wss_pkg::SEL_TWO: s_d.rdata[7:0] = s_q.slot[1];
        default: s_d.rresp = wss_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_q.rvalid && RREADY_IN)
    begin
      s_d.rvalid = 1'b0;
    end
    s_d.arrdy = !s_d.rvalid;
    // sequencer walk
    case (s_q.st)
      wss_pkg::ST_IDLE:
      begin
        s_d.trig = 1'b0;
      end
      wss_pkg::ST_FETCH:
      begin
        if (cur_slot[wss_pkg::DELAY_FLAG_BIT])
        begin
          s_d.ticks = cur_slot[6:0];
          s_d.unit = '0;
          s_d.st = wss_pkg::ST_WAIT;
        end
        else if (cur_slot[6:0] == 7'h00)
        begin
          finish = 1'b1;
        end
        else
        begin
          s_d.eff_idx = cur_slot[6:0];
          s_d.eff_start = 1'b1;
          s_d.st = wss_pkg::ST_PLAY;
        end
      end
      wss_pkg::ST_PLAY:
      begin
        advance = EFFECT_DONE_IN;
      end
      wss_pkg::ST_WAIT:
      begin
        if (s_q.ticks == 7'h00)
        begin
          advance = 1'b1;
        end
        else if (s_q.unit == UNIT_LAST)
        begin
          s_d.unit = '0;
          s_d.ticks = s_q.ticks - 7'h01;
        end
        else
        begin
          s_d.unit = s_q.unit + UNIT_ONE;
        end
      end
      default:
      begin
        s_d.st = wss_pkg::ST_IDLE;
      end
    endcase
    if (advance)
    begin
      if (s_q.idx == wss_pkg::LAST_SLOT)
      begin
        finish = 1'b1;
      end
      else
      begin
        s_d.idx = s_q.idx + 3'h1;
        s_d.st = wss_pkg::ST_FETCH;
      end
    end
    // trigger falls only when the walk is over
    if (finish)
    begin
      s_d.st = wss_pkg::ST_IDLE;
      s_d.trig = 1'b0;
    end
    // host clear cancels whatever is running, in the same cycle
    if (host_clr)
    begin
      s_d.trig = 1'b0;
      s_d.eff_start = 1'b0;
      if (s_q.st != wss_pkg::ST_IDLE)
      begin
        s_d.abort = 1'b1;
        s_d.st = wss_pkg::ST_IDLE;
      end
    end
    // a start request beats a finish landing in the same cycle
    if (trig_set && s_d.st == wss_pkg::ST_IDLE)
    begin
      s_d.trig = 1'b1;
      s_d.idx = wss_pkg::FIRST_SLOT;
      s_d.st = wss_pkg::ST_FETCH;
    end
    s_d.busy = (s_d.st != wss_pkg::ST_IDLE);
    s_d.idle = (s_d.st == wss_pkg::ST_WAIT);
  end

  // single register stage for all state; reset is synchronous
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      s_q <= '0;
      s_q.st <= wss_pkg::ST_IDLE;
      s_q.slot[0] <= wss_pkg::SLOT_ONE_RST;
      s_q.slot[1] <= wss_pkg::SLOT_TWO_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign AWREADY_OUT = s_q.awrdy;
  assign WREADY_OUT = s_q.wrdy;
  assign BVALID_OUT = s_q.bvalid;
  assign BRESP_OUT = s_q.bresp;
  assign ARREADY_OUT = s_q.arrdy;
  assign RVALID_OUT = s_q.rvalid;
  assign RRESP_OUT = s_q.rresp;
  assign RDATA_OUT = s_q.rdata;
  assign EFFECT_INDEX_OUT = s_q.eff_idx;
  assign EFFECT_START_OUT = s_q.eff_start;
  assign PLAY_ABORT_OUT = s_q.abort;
  assign IDLE_OUT = s_q.idle;
  assign BUSY_OUT = s_q.busy;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  // steps of a slot being fetched and played
  sequence seq_fetch_effect;
    s_q.st == wss_pkg::ST_FETCH && !cur_slot[wss_pkg::DELAY_FLAG_BIT];
  endsequence
  sequence seq_play_done;
    s_q.st == wss_pkg::ST_PLAY && EFFECT_DONE_IN && !host_clr && !trig_set;
  endsequence

  chk_delay_idle: assert property (s_q.st == wss_pkg::ST_WAIT |-> IDLE_OUT && !EFFECT_START_OUT)
    else $error("idle output low during a delay slot");
  chk_delay_step: assert property (s_q.st == wss_pkg::ST_WAIT && s_q.ticks != 7'h00 && !host_clr
    && s_q.unit == UNIT_LAST |=> s_q.ticks == $past(s_q.ticks) - 7'h01 && s_q.unit == '0)
    else $error("delay step not taken at unit end");
  chk_effect_index: assert property (seq_fetch_effect and cur_slot[6:0] != 7'h00 && !host_clr
    |=> EFFECT_START_OUT && EFFECT_INDEX_OUT == $past(cur_slot[6:0]))
    else $error("effect index differs from slot");
  chk_start_first: assert property ($rose(BUSY_OUT) |-> s_q.idx == wss_pkg::FIRST_SLOT
    && s_q.st == wss_pkg::ST_FETCH)
    else $error("sequence did not start at first slot");
  chk_advance_next: assert property (seq_play_done and s_q.idx != wss_pkg::LAST_SLOT
    |=> s_q.st == wss_pkg::ST_FETCH && s_q.idx == $past(s_q.idx) + 3'h1)
    else $error("sequencer did not advance");
  chk_stop_zero: assert property (seq_fetch_effect and cur_slot[6:0] == 7'h00 && !trig_set
    |=> !BUSY_OUT && !EFFECT_START_OUT && !s_q.trig)
    else $error("zero index did not stop the sequence");
  chk_end_last: assert property (seq_play_done and s_q.idx == wss_pkg::LAST_SLOT
    |=> s_q.st == wss_pkg::ST_IDLE ##1 !BUSY_OUT)
    else $error("sequence ran past last slot");
  chk_trig_held: assert property (BUSY_OUT |-> s_q.trig)
    else $error("trigger low while sequence running");
  chk_abort_now: assert property (host_clr && !trig_set && s_q.st != wss_pkg::ST_IDLE
    |=> !BUSY_OUT && PLAY_ABORT_OUT && !s_q.trig)
    else $error("host clear did not abort");
  chk_wait_next: assert property (s_q.st == wss_pkg::ST_WAIT && s_q.ticks == 7'h00 && !host_clr
    && !trig_set && s_q.idx != wss_pkg::LAST_SLOT |=> s_q.st == wss_pkg::ST_FETCH)
    else $error("elapsed delay did not advance");
endmodule

// ==== tb/test_waveform_sequence_slots.sv ====
// self-checking bench for the waveform sequence slots block
`timescale 1ns/1ps
module test_waveform_sequence_slots;
  // short idle step keeps delay slots cheap to simulate
  localparam int DLY = 4;
  // clock, reset and bus stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ext_trig = 1'b0;
  logic eff_done = 1'b0;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid, eff_start, abort_p, idle, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] eff_idx;
  // bookkeeping and last bus results
  int n_mismatch = 0, n_tests = 0, n_start = 0, n_abort = 0, idle_cnt = 0, cyc = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [7:0] e1, e2, n;

  wss_top #(.DELAY_CYCLES(DLY)) u_wss_top (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .EXT_TRIG_IN(ext_trig), .EFFECT_INDEX_OUT(eff_idx), .EFFECT_START_OUT(eff_start),
    .PLAY_ABORT_OUT(abort_p), .EFFECT_DONE_IN(eff_done), .IDLE_OUT(idle), .BUSY_OUT(busy)
  );

  // free-running 10 MHz clock
  initial forever #50 clk = ~clk;

  // monitor: pulse and idle counters, plus the hang limit
  always @(posedge clk)
  begin
    cyc++;
    if (eff_start === 1'b1) n_start++;
    if (abort_p === 1'b1) n_abort++;
    if (idle === 1'b1) idle_cnt++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // value compare; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // axi4-lite write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count is assumed: only the bench timeout ends this wait
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read: rready held until the data beat is seen
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // no cycle count is assumed: only the bench timeout ends this wait
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // wait for a start pulse and check the library index it carries
  task automatic wait_start(input logic [6:0] e);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (eff_start === 1'b1) break;
    end
    chk({31'h0, eff_start}, 32'h1, "start pulse");
    chk({25'h0, eff_idx}, {25'h0, e}, "effect index");
  endtask

  // one-cycle completion from the playback engine
  task automatic fin_eff();
    eff_done <= 1'b1;
    @(posedge clk);
    eff_done <= 1'b0;
  endtask

  // bounded wait for the sequence to end
  task automatic wait_busy_low();
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    chk({31'h0, busy}, 32'h0, "busy after end");
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h07940cc4));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped place and random readback
    axr(wss_pkg::ADDR_SLOT_ONE);
    chk(rd, 32'h01, "slot one reset");
    axr(wss_pkg::ADDR_SLOT_TWO);
    chk(rd, 32'h00, "slot two reset");
    axr(wss_pkg::ADDR_CTRL);
    chk(rd, 32'h00, "ctrl reset");
    axr(8'h44);
    chk({30'h0, resp}, {30'h0, wss_pkg::RESP_SLVERR}, "unmapped read");
    axw(8'h44, 8'hA5);
    chk({30'h0, resp}, {30'h0, wss_pkg::RESP_SLVERR}, "unmapped write");
    for (int i = 0; i < 4; i++)
    begin
      e1 = 8'($urandom);
      axw(wss_pkg::ADDR_SLOT_ONE, e1);
      axw(wss_pkg::ADDR_SLOT_TWO, ~e1);
      axr(wss_pkg::ADDR_SLOT_ONE);
      chk(rd, {24'h0, e1}, "slot one readback");
      axr(wss_pkg::ADDR_SLOT_TWO);
      chk(rd, {24'h0, ~e1}, "slot two readback");
    end
    // a write with the low lane disabled leaves the slot alone
    wstrb <= 4'hE;
    axw(wss_pkg::ADDR_SLOT_ONE, ~e1);
    wstrb <= 4'hF;
    chk({30'h0, resp}, {30'h0, wss_pkg::RESP_OKAY}, "masked write response");
    axr(wss_pkg::ADDR_SLOT_ONE);
    chk(rd, {24'h0, e1}, "masked write ignored");
    end_test("registers");
    // two effects back to back, then the zero slots end the walk
    e1 = 8'(1 + $urandom % 127);
    e2 = 8'(1 + $urandom % 127);
    axw(wss_pkg::ADDR_SLOT_ONE, e1);
    axw(wss_pkg::ADDR_SLOT_TWO, e2);
    n_start = 0;
    axw(wss_pkg::ADDR_CTRL, 8'h01);
    wait_start(e1[6:0]);
    axr(wss_pkg::ADDR_CTRL);
    chk(rd, 32'h3, "trigger held while playing");
    fin_eff();
    wait_start(e2[6:0]);
    fin_eff();
    wait_busy_low();
    axr(wss_pkg::ADDR_CTRL);
    chk({31'h0, rd[0]}, 32'h0, "trigger cleared at end");
    chk(n_start, 2, "effects played");
    end_test("two effects");
    // zero index in the first slot plays nothing
    axw(wss_pkg::ADDR_SLOT_ONE, 8'h00);
    n_start = 0;
    axw(wss_pkg::ADDR_CTRL, 8'h01);
    wait_busy_low();
    chk(n_start, 0, "nothing played");
    end_test("zero slot");
    // delay slot followed by an effect
    n = 8'(1 + $urandom % 5);
    axw(wss_pkg::ADDR_SLOT_ONE, 8'h80 | n);
    n_start = 0;
    idle_cnt = 0;
    axw(wss_pkg::ADDR_CTRL, 8'h01);
    wait_start(e2[6:0]);
    chk(idle_cnt, 32'(n) * DLY + 1, "idle length");
    fin_eff();
    wait_busy_low();
    // counted after the walk so the monitor has seen the start pulse
    chk(n_start, 1, "no waveform in delay");
    end_test("delay slot");
    // host clears the trigger in mid-effect
    axw(wss_pkg::ADDR_SLOT_ONE, e1);
    n_abort = 0;
    axw(wss_pkg::ADDR_CTRL, 8'h01);
    wait_start(e1[6:0]);
    axw(wss_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk(n_abort, 1, "abort pulse");
    chk({31'h0, busy}, 32'h0, "busy after abort");
    end_test("abort");
    // pin trigger starts at the first slot
    axw(wss_pkg::ADDR_SLOT_TWO, 8'h00);
    n_start = 0;
    ext_trig <= 1'b1;
    wait_start(e1[6:0]);
    fin_eff();
    wait_busy_low();
    ext_trig <= 1'b0;
    chk(n_start, 1, "pin start count");
    end_test("pin trigger");
    print_verdict();
  end
endmodule
